// *** src/reset_cause_status_flags.sv ***
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - Priority enable picks two levels or legacy
// - Long write enable allows internal table writes
// - Disabled: internal writes blocked, external only
// - Long write cleared only by power-on/pin
// - Unused bit reads zero, ignores writes
// - Reset instruction flag zero after instruction reset
// - Watchdog flag set at power-up, clear, sleep
// - Watchdog flag cleared on watchdog time-out
// - Sleep flag set power-up/clear, cleared sleeping
// - Power-on flag zero until software writes one
// - Supply dip flag zero after supply dip reset
module reset_cause_status_flags
   import rcause_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic              power_on_rst,
   input  wire logic              supply_dip_rst,
   input  wire logic              external_reset_pin,
   input  wire logic              reset_instr_rst,
   input  wire logic              watchdog_reset,
   input  wire logic              watchdog_clear_op,
   input  wire logic              sleep_op,
   input  wire logic              watchdog_timeout,
   input  wire logic              table_write_op,
   input  wire logic              table_write_internal,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [7:0]        reg_rdata_q,
   output logic                   irq_q,
   output logic                   two_level_q,
   output logic                   legacy_mode_q,
   output logic                   int_wr_q,
   output logic                   ext_wr_q,
   output logic                   wr_blocked_q
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic          prio_en_q;
   logic          long_wr_q;
   logic          reset_instr_flag_q;
   logic          wdog_expiry_flag_q;
   logic          sleep_entry_flag_q;
   logic          power_on_flag_q;
   logic          supply_dip_reset_flag_q;
   logic [EV_W-1:0] ev_stat_q;
   logic [EV_W-1:0] ev_mask_q;
   logic [EV_W-1:0] ev_set;
   logic          any_reset;
   logic          long_wr_kill;
   logic          rctrl_wr;
   logic [7:0]    rctrl_view;
   cause_t        cause;

   // Software write to the control register
   assign rctrl_wr = reg_wr && (reg_addr == OFF_RCTRL);

   // Any core reset request; the OR sets no priority, the cause decode does
   assign any_reset = power_on_rst || supply_dip_rst || external_reset_pin
                    || reset_instr_rst || watchdog_reset;

   // Only a power-on or pin reset may drop long write enable
   assign long_wr_kill = (cause == CAUSE_POWER_ON) || (cause == CAUSE_PIN);

   // ---------------------------------------------------------------
   // Reset cause decode
   // ---------------------------------------------------------------
   // Priority keeps the power-on cause dominant when several coincide
   always_comb begin
      if (power_on_rst)            cause = CAUSE_POWER_ON;
      else if (external_reset_pin) cause = CAUSE_PIN;      // Must beat dip: drops long write
      else if (supply_dip_rst)     cause = CAUSE_SUPPLY_DIP;
      else if (reset_instr_rst)    cause = CAUSE_INSTR;
      else if (watchdog_reset)     cause = CAUSE_WDOG;
      else                         cause = CAUSE_NONE;
   end

   // Software value bit taken straight from the write data, no mask applied
   function automatic logic sw_bit(input logic [7:0] d, input int pos);
      sw_bit = d[pos];
   endfunction

   // ---------------------------------------------------------------
   // Priority enable: plain read/write, cleared by any reset
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prio_en_q <= 1'b0;
      end else if (any_reset) begin
         prio_en_q <= 1'b0;
      end else if (rctrl_wr) begin
         prio_en_q <= sw_bit(reg_wdata, BIT_PRIO_EN);
      end
   end

   // ---------------------------------------------------------------
   // Long write enable: set-only from software
   // ---------------------------------------------------------------
   // Writing zero is ignored so a runaway program cannot drop it early
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         long_wr_q <= 1'b0;
      end else begin
         case (cause)
            CAUSE_POWER_ON, CAUSE_PIN: begin
               long_wr_q <= 1'b0;
            end
            default: begin
               if (rctrl_wr && sw_bit(reg_wdata, BIT_LONG_WR)) begin
                  long_wr_q <= 1'b1;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Reset instruction flag
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reset_instr_flag_q <= RCTRL_RESET[BIT_RESET_INSTR];
      end else if (reset_instr_rst) begin
         reset_instr_flag_q <= 1'b0;
      end else if (rctrl_wr) begin
         reset_instr_flag_q <= sw_bit(reg_wdata, BIT_RESET_INSTR);
      end
   end

   // ---------------------------------------------------------------
   // Watchdog expiry flag
   // ---------------------------------------------------------------
   // Time-out outranks clear and sleep, so a late expiry is never hidden
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wdog_expiry_flag_q <= RCTRL_RESET[BIT_WDOG_EXP];
      end else if (watchdog_timeout) begin
         wdog_expiry_flag_q <= 1'b0;
      end else if (power_on_rst || watchdog_clear_op || sleep_op) begin
         wdog_expiry_flag_q <= 1'b1;
      end else if (rctrl_wr) begin
         wdog_expiry_flag_q <= sw_bit(reg_wdata, BIT_WDOG_EXP);
      end
   end

   // ---------------------------------------------------------------
   // Sleep entry flag
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sleep_entry_flag_q <= RCTRL_RESET[BIT_SLEEP_ENT];
      end else if (sleep_op) begin
         sleep_entry_flag_q <= 1'b0;
      end else if (power_on_rst || watchdog_clear_op) begin
         sleep_entry_flag_q <= 1'b1;
      end else if (rctrl_wr) begin
         sleep_entry_flag_q <= sw_bit(reg_wdata, BIT_SLEEP_ENT);
      end
   end

   // ---------------------------------------------------------------
   // Power-on and supply dip flags
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         power_on_flag_q <= RCTRL_RESET[BIT_POWER_ON];
      end else if (power_on_rst) begin
         power_on_flag_q <= 1'b0;
      end else if (rctrl_wr && sw_bit(reg_wdata, BIT_POWER_ON)) begin
         power_on_flag_q <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         supply_dip_reset_flag_q <= RCTRL_RESET[BIT_SUPPLY_DIP];
      end else if (supply_dip_rst) begin
         supply_dip_reset_flag_q <= 1'b0;
      end else if (rctrl_wr) begin
         supply_dip_reset_flag_q <= sw_bit(reg_wdata, BIT_SUPPLY_DIP);
      end
   end

   // ---------------------------------------------------------------
   // Register view; unused bit forced low
   // ---------------------------------------------------------------
   always_comb begin
      rctrl_view                  = 8'h00;
      rctrl_view[BIT_PRIO_EN]     = prio_en_q;
      rctrl_view[BIT_LONG_WR]     = long_wr_q;
      rctrl_view[BIT_RESET_INSTR] = reset_instr_flag_q;
      rctrl_view[BIT_WDOG_EXP]    = wdog_expiry_flag_q;
      rctrl_view[BIT_SLEEP_ENT]   = sleep_entry_flag_q;
      rctrl_view[BIT_POWER_ON]    = power_on_flag_q;
      rctrl_view[BIT_SUPPLY_DIP]  = supply_dip_reset_flag_q;
   end

   // ---------------------------------------------------------------
   // Events and interrupt
   // ---------------------------------------------------------------
   always_comb begin
      ev_set                 = EV_RESET;
      ev_set[EV_WDOG]        = watchdog_timeout;
      ev_set[EV_SLEEP]       = sleep_op;
      ev_set[EV_RESET_INSTR] = reset_instr_rst;
      ev_set[EV_BLOCKED_WR]  = wr_blocked_q;
      // No turn-on event when a reset drops the bit in the same cycle
      ev_set[EV_LONG_WR_ON]  = rctrl_wr && !long_wr_q && !long_wr_kill
                               && reg_wdata[BIT_LONG_WR];
   end

   // Set wins over a write-one-to-clear in the same cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ev_stat_q <= EV_RESET;
      end else if (reg_wr && (reg_addr == OFF_IRQ_STAT)) begin
         ev_stat_q <= (ev_stat_q & ~reg_wdata[EV_W-1:0]) | ev_set;
      end else begin
         ev_stat_q <= ev_stat_q | ev_set;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ev_mask_q <= EV_RESET;
      end else if (reg_wr && (reg_addr == OFF_IRQ_MASK)) begin
         ev_mask_q <= reg_wdata[EV_W-1:0];
      end
   end

   // One cycle behind the status bits, kept flop-driven
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(ev_stat_q & ev_mask_q);
      end
   end

   // ---------------------------------------------------------------
   // Read port: data valid the cycle after the strobe only
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            OFF_RCTRL:     reg_rdata_q <= rctrl_view;
            OFF_IRQ_STAT:  reg_rdata_q <= {3'h0, ev_stat_q};
            OFF_IRQ_MASK:  reg_rdata_q <= {3'h0, ev_mask_q};
            OFF_PROT_STAT: reg_rdata_q <= {5'h00, wr_blocked_q, ext_wr_q, int_wr_q};
            default:       reg_rdata_q <= 8'h00;
         endcase
      end else begin
         reg_rdata_q <= 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // Submodules
   // ---------------------------------------------------------------
   table_write_gate u_gate (
      .clk                  (clk),
      .resetn               (resetn),
      .long_write_enable    (long_wr_q),
      .table_write_op       (table_write_op),
      .table_write_internal (table_write_internal),
      .int_wr_q             (int_wr_q),
      .ext_wr_q             (ext_wr_q),
      .blocked_q            (wr_blocked_q)
   );

   prio_mode_select u_prio (
      .clk           (clk),
      .resetn        (resetn),
      .prio_enable   (prio_en_q),
      .two_level_q   (two_level_q),
      .legacy_mode_q (legacy_mode_q)
   );

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   AST_LONG_WR_STICKY: assert property (@(posedge clk) disable iff (!resetn)
      long_wr_q && !power_on_rst && !external_reset_pin |=> long_wr_q)
      else $error("long write enable dropped without reset");
   AST_UNUSED_ZERO: assert property (@(posedge clk) disable iff (!resetn)
      reg_rd && reg_addr == OFF_RCTRL |=> !reg_rdata_q[BIT_UNUSED])
      else $error("unused bit read as one");
   AST_INSTR_CLR: assert property (@(posedge clk) disable iff (!resetn)
      reset_instr_rst |=> !reset_instr_flag_q)
      else $error("reset instruction flag not cleared");
   AST_WDOG_SET: assert property (@(posedge clk) disable iff (!resetn)
      (watchdog_clear_op || sleep_op) && !watchdog_timeout |=> wdog_expiry_flag_q)
      else $error("watchdog flag not set");
   AST_WDOG_CLR: assert property (@(posedge clk) disable iff (!resetn)
      watchdog_timeout |=> !wdog_expiry_flag_q)
      else $error("watchdog flag not cleared on time-out");
   AST_SLEEP_FLAG: assert property (@(posedge clk) disable iff (!resetn)
      sleep_op |=> !sleep_entry_flag_q)
      else $error("sleep flag not cleared by sleep");
   AST_SLEEP_HOLD: assert property (@(posedge clk) disable iff (!resetn)
      !sleep_entry_flag_q && !watchdog_clear_op && !power_on_rst && !rctrl_wr
         |=> !sleep_entry_flag_q)
      else $error("sleep flag rose without clear or power-up");
   AST_POR_HOLD: assert property (@(posedge clk) disable iff (!resetn)
      !power_on_flag_q && !(rctrl_wr && reg_wdata[BIT_POWER_ON]) |=> !power_on_flag_q)
      else $error("power-on flag set without software");
   AST_DIP_CLR: assert property (@(posedge clk) disable iff (!resetn)
      supply_dip_rst |=> !supply_dip_reset_flag_q)
      else $error("supply dip flag not cleared");

   // ---------------------------------------------------------------
   // Reset and hardware event checks
   // ---------------------------------------------------------------
   // Pin and power-on resets must drop long write even with a dip
   AST_LONG_WR_CLR: assert property (@(posedge clk) disable iff (!resetn)
      power_on_rst || external_reset_pin |=> !long_wr_q)
      else $error("long write enable kept over reset");
   // Long write rises only by a software write of one
   AST_LONG_WR_RISE: assert property (@(posedge clk) disable iff (!resetn)
      !long_wr_q && !(rctrl_wr && reg_wdata[BIT_LONG_WR]) |=> !long_wr_q)
      else $error("long write enable rose without software");
   // Power-on reset leaves the flag low for software to re-arm
   AST_POR_CLR: assert property (@(posedge clk) disable iff (!resetn)
      power_on_rst |=> !power_on_flag_q)
      else $error("power-on flag not cleared");
   // Power-up sets the watchdog flag unless a time-out lands with it
   AST_WDOG_PWRUP: assert property (@(posedge clk) disable iff (!resetn)
      power_on_rst && !watchdog_timeout |=> wdog_expiry_flag_q)
      else $error("watchdog flag not set at power-up");
   // Clear or power-up brings the sleep flag back unless sleep wins
   AST_SLEEP_SET: assert property (@(posedge clk) disable iff (!resetn)
      (watchdog_clear_op || power_on_rst) && !sleep_op |=> sleep_entry_flag_q)
      else $error("sleep flag not set by clear or power-up");
   // No reset instruction, no write: the flag keeps reading one
   AST_INSTR_KEEP: assert property (@(posedge clk) disable iff (!resetn)
      reset_instr_flag_q && !reset_instr_rst && !rctrl_wr |=> reset_instr_flag_q)
      else $error("reset instruction flag dropped on its own");
   // No supply dip, no write: the flag keeps reading one
   AST_DIP_KEEP: assert property (@(posedge clk) disable iff (!resetn)
      supply_dip_reset_flag_q && !supply_dip_rst && !rctrl_wr |=> supply_dip_reset_flag_q)
      else $error("supply dip flag dropped on its own");
endmodule

// *** src/rcause_pkg.sv ***
package rcause_pkg;
   // ---------------------------------------------------------------
   // Register map (word offsets on the plain register port)
   // ---------------------------------------------------------------
   localparam int          ADDR_W          = 4;
   localparam logic [3:0]  OFF_RCTRL       = 4'h0;   // Reset control and cause
   localparam logic [3:0]  OFF_IRQ_STAT    = 4'h1;   // Sticky event bits, write one clears
   localparam logic [3:0]  OFF_IRQ_MASK    = 4'h2;   // Event enables
   localparam logic [3:0]  OFF_PROT_STAT   = 4'h3;   // Table write routing, read only

   // ---------------------------------------------------------------
   // Control register fields
   // ---------------------------------------------------------------
   localparam int          BIT_PRIO_EN     = 7;
   localparam int          BIT_LONG_WR     = 6;
   localparam int          BIT_UNUSED      = 5;
   localparam int          BIT_RESET_INSTR = 4;
   localparam int          BIT_WDOG_EXP    = 3;
   localparam int          BIT_SLEEP_ENT   = 2;
   localparam int          BIT_POWER_ON    = 1;
   localparam int          BIT_SUPPLY_DIP  = 0;
   localparam logic [7:0]  RCTRL_RESET     = 8'h1C;
   localparam logic [7:0]  RCTRL_WMASK     = 8'hDF;

   // ---------------------------------------------------------------
   // Interrupt event bits
   // ---------------------------------------------------------------
   localparam int          EV_W            = 5;
   localparam int          EV_WDOG         = 0;
   localparam int          EV_SLEEP        = 1;
   localparam int          EV_RESET_INSTR  = 2;
   localparam int          EV_BLOCKED_WR   = 3;
   localparam int          EV_LONG_WR_ON   = 4;
   localparam logic [4:0]  EV_RESET        = 5'h00;

   // Reset cause classes used by the combinational cause decode
   typedef enum logic [2:0] {
      CAUSE_NONE, CAUSE_POWER_ON, CAUSE_SUPPLY_DIP, CAUSE_PIN, CAUSE_INSTR, CAUSE_WDOG
   } cause_t;
endpackage

// *** src/table_write_gate.sv ***
`timescale 1ns/1ps
// Routes a table write to internal or external program memory
module table_write_gate
   import rcause_pkg::*;
(
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic long_write_enable,
   input  wire logic table_write_op,
   input  wire logic table_write_internal,
   output logic      int_wr_q,
   output logic      ext_wr_q,
   output logic      blocked_q
);
   // ---------------------------------------------------------------
   // Routing, registered so outputs come straight from flops
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         int_wr_q  <= 1'b0;
         ext_wr_q  <= 1'b0;
         blocked_q <= 1'b0;
      end else begin
         int_wr_q  <= table_write_op && table_write_internal && long_write_enable;
         ext_wr_q  <= table_write_op && !table_write_internal;
         blocked_q <= table_write_op && table_write_internal && !long_write_enable;
      end
   end

   AST_INT_BLOCKED: assert property (@(posedge clk) disable iff (!resetn)
      table_write_op && table_write_internal && !long_write_enable
         |=> !int_wr_q && blocked_q)
      else $error("internal table write passed while disabled");
   AST_INT_ALLOWED: assert property (@(posedge clk) disable iff (!resetn)
      table_write_op && table_write_internal && long_write_enable |=> int_wr_q)
      else $error("internal table write not issued while enabled");
endmodule

// *** src/prio_mode_select.sv ***
`timescale 1ns/1ps
// Selects two-level or single-level interrupt handling
module prio_mode_select
   import rcause_pkg::*;
(
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic prio_enable,
   output logic      two_level_q,
   output logic      legacy_mode_q
);
   // ---------------------------------------------------------------
   // Mode flops, mutually exclusive by construction
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         two_level_q   <= 1'b0;
         legacy_mode_q <= 1'b1;
      end else begin
         two_level_q   <= prio_enable;
         legacy_mode_q <= !prio_enable;
      end
   end

   AST_PRIO_MODE: assert property (@(posedge clk) disable iff (!resetn)
      ##1 (two_level_q == $past(prio_enable)) && (legacy_mode_q != two_level_q))
      else $error("priority mode does not follow enable bit");
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Bench for the reset cause and status flag block
// ---------------------------------------------------------------
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value %s: expected %0h seen %0h", nm, e, g); end end
module tb_top;
   import rcause_pkg::*;
   logic              clk;
   logic              resetn;
   logic [7:0]        ev;
   logic              table_write_op;
   logic              table_write_internal;
   logic [ADDR_W-1:0] reg_addr;
   logic [7:0]        reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [7:0]        reg_rdata_q;
   logic              irq_q;
   logic              two_level_q;
   logic              legacy_mode_q;
   logic              int_wr_q;
   logic              ext_wr_q;
   logic              wr_blocked_q;
   logic [7:0]        d;
   int                mismatches;
   int                n_checks;

   // Event pulses: 0 power-on, 1 supply dip, 2 pin, 3 instr, 4 wdog reset, 5 clear, 6 sleep, 7 tmo
   reset_cause_status_flags u_reset_cause_status_flags (
      .clk                  (clk),
      .resetn               (resetn),
      .power_on_rst         (ev[0]),
      .supply_dip_rst       (ev[1]),
      .external_reset_pin   (ev[2]),
      .reset_instr_rst      (ev[3]),
      .watchdog_reset       (ev[4]),
      .watchdog_clear_op    (ev[5]),
      .sleep_op             (ev[6]),
      .watchdog_timeout     (ev[7]),
      .table_write_op       (table_write_op),
      .table_write_internal (table_write_internal),
      .reg_addr             (reg_addr),
      .reg_wdata            (reg_wdata),
      .reg_wr               (reg_wr),
      .reg_rd               (reg_rd),
      .reg_rdata_q          (reg_rdata_q),
      .irq_q                (irq_q),
      .two_level_q          (two_level_q),
      .legacy_mode_q        (legacy_mode_q),
      .int_wr_q             (int_wr_q),
      .ext_wr_q             (ext_wr_q),
      .wr_blocked_q         (wr_blocked_q)
   );

   // 200 MHz clock
   always #2.5 clk = ~clk;

   // ---------------------------------------------------------------
   // Bus and event helpers
   // ---------------------------------------------------------------
   // Strobe sits one cycle, so a gap edge separates transfers
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata_q;
   endtask

   task automatic pulse(input int i);
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev[i] <= 1'b0;
   endtask

   // Routing outputs pulse one cycle after the request, then fall
   task automatic tw(input logic internal, input logic [2:0] exp);
      @(posedge clk);
      table_write_op <= 1'b1; table_write_internal <= internal;
      @(posedge clk);
      table_write_op <= 1'b0;
      #1 `CHK("routing", exp, {wr_blocked_q, ext_wr_q, int_wr_q})
      @(posedge clk);
      #1 `CHK("routing idle", 3'h0, {wr_blocked_q, ext_wr_q, int_wr_q})
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      rd(OFF_RCTRL, d);
      `CHK("ctrl reset", RCTRL_RESET, d)
      `CHK("legacy", 1'b1, legacy_mode_q)
      rd(4'hF, d);
      `CHK("unmapped", 8'h00, d)
      $display("test reset done");
   endtask

   task automatic t_prio();
      wr(OFF_RCTRL, 8'h9C);
      @(posedge clk);
      #1 `CHK("two level", 2'b10, {two_level_q, legacy_mode_q})
      wr(OFF_RCTRL, 8'h1C);
      @(posedge clk);
      #1 `CHK("single level", 2'b01, {two_level_q, legacy_mode_q})
      $display("test prio done");
   endtask

   task automatic t_tblwr();
      tw(1'b1, 3'h4);
      tw(1'b0, 3'h2);
      wr(OFF_RCTRL, 8'h5C);
      tw(1'b1, 3'h1);
      // A zero written to the enable must not drop it
      wr(OFF_RCTRL, 8'h1C);
      rd(OFF_RCTRL, d);
      `CHK("long write kept", 1'b1, d[BIT_LONG_WR])
      // Watchdog and supply dip resets must leave it set
      pulse(4);
      pulse(1);
      rd(OFF_RCTRL, d);
      `CHK("long write other reset", 1'b1, d[BIT_LONG_WR])
      pulse(2);
      rd(OFF_RCTRL, d);
      `CHK("long write pin", 1'b0, d[BIT_LONG_WR])
      tw(1'b1, 3'h4);
      // Routing status read while the blocked pulse stands
      @(posedge clk);
      table_write_op <= 1'b1; table_write_internal <= 1'b1;
      @(posedge clk);
      table_write_op <= 1'b0; reg_addr <= OFF_PROT_STAT; reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 `CHK("routing status", 8'h04, reg_rdata_q)
      $display("test table write done");
   endtask

   task automatic t_unused();
      wr(OFF_RCTRL, 8'hFF);
      rd(OFF_RCTRL, d);
      `CHK("all ones", RCTRL_WMASK, d)
      pulse(2);
      wr(OFF_RCTRL, 8'h1C);
      $display("test unused done");
   endtask

   task automatic t_instr();
      pulse(3);
      rd(OFF_RCTRL, d);
      `CHK("instr flag", 1'b0, d[BIT_RESET_INSTR])
      wr(OFF_RCTRL, 8'h1C);
      rd(OFF_RCTRL, d);
      `CHK("instr rearm", 1'b1, d[BIT_RESET_INSTR])
      // Hardware clear and software set land on the same edge
      @(posedge clk);
      reg_addr <= OFF_RCTRL; reg_wdata <= 8'h1C; reg_wr <= 1'b1; ev[3] <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0; ev[3] <= 1'b0;
      rd(OFF_RCTRL, d);
      `CHK("instr race", 1'b0, d[BIT_RESET_INSTR])
      wr(OFF_RCTRL, 8'h1C);
      $display("test reset instr done");
   endtask

   task automatic t_wdog();
      pulse(7);
      rd(OFF_RCTRL, d);
      `CHK("wdog tmo", 2'b01, d[3:2])
      pulse(5);
      rd(OFF_RCTRL, d);
      `CHK("wdog clear", 2'b11, d[3:2])
      pulse(7);
      pulse(6);
      rd(OFF_RCTRL, d);
      `CHK("sleep", 2'b10, d[3:2])
      pulse(5);
      $display("test watchdog done");
   endtask

   task automatic t_supply();
      wr(OFF_RCTRL, 8'h1D);
      pulse(1);
      rd(OFF_RCTRL, d);
      `CHK("dip flag", 1'b0, d[BIT_SUPPLY_DIP])
      wr(OFF_RCTRL, 8'h5F);
      rd(OFF_RCTRL, d);
      `CHK("rearm", 8'h5F, d)
      pulse(0);
      wr(OFF_RCTRL, 8'h1D);
      rd(OFF_RCTRL, d);
      `CHK("power on", 2'b00, {d[BIT_LONG_WR], d[BIT_POWER_ON]})
      wr(OFF_RCTRL, 8'h1E);
      rd(OFF_RCTRL, d);
      `CHK("power on set", 1'b1, d[BIT_POWER_ON])
      $display("test supply done");
   endtask

   task automatic t_irq();
      wr(OFF_IRQ_STAT, 8'h1F);
      wr(OFF_IRQ_MASK, 8'h01);
      // Status sets on the event edge, the interrupt one edge later
      pulse(7);
      #1 `CHK("irq early", 1'b0, irq_q)
      @(posedge clk);
      #1 `CHK("irq up", 1'b1, irq_q)
      rd(OFF_IRQ_STAT, d);
      `CHK("stat", 8'h01, d)
      wr(OFF_IRQ_STAT, 8'h01);
      repeat (3) @(posedge clk);
      #1 `CHK("irq cleared", 1'b0, irq_q)
      wr(OFF_IRQ_MASK, 8'h00);
      pulse(7);
      repeat (4) @(posedge clk);
      #1 `CHK("irq masked", 1'b0, irq_q)
      rd(OFF_IRQ_STAT, d);
      `CHK("stat masked", 8'h01, d)
      $display("test irq done");
   endtask

   // ---------------------------------------------------------------
   // Verdict, watchdog and main sequence
   // ---------------------------------------------------------------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Whole run is well under 2000 cycles; this cuts a hang
   initial begin
      #50000;
      mismatches++;
      give_verdict();
   end

   initial begin
      clk = 1'b0; resetn = 1'b0; ev = 8'h00; table_write_op = 1'b0;
      table_write_internal = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00;
      reg_wr = 1'b0; reg_rd = 1'b0; mismatches = 0; n_checks = 0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_prio();
      t_tblwr();
      t_unused();
      t_instr();
      t_wdog();
      t_supply();
      t_irq();
      give_verdict();
   end
endmodule
